// *** timer_cc_pkg.sv ***
// Package for the 16-bit capture/compare timer: register map, field
// positions, reset values, mode codes and the AHB-Lite carrier structs.
// Assumes a single AHB-Lite master and word-only accesses.
package timer_cc_pkg;

  // Register byte offsets
  localparam logic [7:0] mode_control_off = 8'h00;
  localparam logic [7:0] output_control_off = 8'h04;
  localparam logic [7:0] prescaler_mode_off = 8'h08;
  localparam logic [7:0] capture_control_off = 8'h0c;
  localparam logic [7:0] capcomp_first_off = 8'h10;
  localparam logic [7:0] capcomp_second_off = 8'h14;
  localparam logic [7:0] timer_count_off = 8'h18;

  // mode_control fields
  localparam int mode_pos = 0;
  localparam int overflow_pos = 2;
  // output_control fields
  localparam int first_rev_pos = 0;
  localparam int second_rev_pos = 1;
  localparam int level_set_pos = 2;
  localparam int level_clear_pos = 3;
  localparam int oneshot_en_pos = 4;
  localparam int oneshot_trig_pos = 5;
  // prescaler_mode fields
  localparam int edge_first_pos = 0;
  localparam int edge_second_pos = 2;
  localparam int clk_sel_pos = 4;
  // capture_control fields
  localparam int cap_first_pos = 0;
  localparam int reverse_phase_pos = 1;
  localparam int cap_second_pos = 2;

  // Reset values and the top count value
  localparam logic [15:0] capcomp_reset = 16'h0000;
  localparam logic [15:0] count_max = 16'hffff;
  localparam logic [1:0] clk_div_reset = 2'h0;

  // Operating mode codes
  localparam logic [1:0] mode_stop = 2'h0;
  localparam logic [1:0] mode_free = 2'h1;
  localparam logic [1:0] mode_clear_edge = 2'h2;
  localparam logic [1:0] mode_clear_match = 2'h3;

  // Edge select codes
  localparam logic [1:0] edge_fall = 2'h0;
  localparam logic [1:0] edge_rise = 2'h1;
  localparam logic [1:0] edge_both = 2'h3;

  // Count clock select: 0..2 divide by 2**sel, 3 first input edge
  localparam logic [1:0] clk_from_input = 2'h3;

  localparam logic [1:0] htrans_nonseq = 2'h2;

  typedef struct packed {
    logic hsel;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
  } ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } ahb_rsp_t;

endpackage

// *** timer_capture_compare_output_control.sv ***
// 16-bit timer/event counter with two capture/compare registers, one
// timer output and two capture inputs, behind an AHB-Lite slave.
// Assumes capture inputs are already synchronous to i_sys_clk.
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Level set/clear bits: 00 unchanged, 01 output low, 10 high, 11 prohibited.
// - On start the output begins from the level last forced.
// - Returning set/clear bits to 00 keeps the forced level.
// - First-compare reversal toggles output at each first match interrupt.
// - First match after start may be late by up to one count clock.
// - Capture during a register read still happens and interrupts; read value undefined.
// - Capture/compare contents need not be kept after the timer stops.
// - Overflow also set when first compare is FFFF and counter wraps on match.
// - Clearing overflow before the next count clock has no effect.
// - One-shot works in free-run and edge-clear modes, not match-clear mode.
// - With first input edge as count clock, its captures do not work.
// - Capture at count clock, capture interrupt at the following count clock.
// - Reverse-phase capture raises no first interrupt; second input edge does instead.
// - First enable after reset treats an already-high input as rising edge.
// - Mode 00 stop, 01 free-running, 10 clear on first input edge.
module timer_capture_compare_output_control (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // AHB-Lite slave
  input wire timer_cc_pkg::ahb_req_t i_ahb,
  input wire logic i_hready,
  output timer_cc_pkg::ahb_rsp_t o_ahb,
  // Timer pins
  input wire logic i_first_capture_input,
  input wire logic i_second_capture_input,
  output logic o_timer_output_pin,
  // Event pulses
  output logic o_first_match_irq,
  output logic o_second_match_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Control state
  logic [1:0] mode;
  logic overflow_flag;
  logic first_rev_en;
  logic second_match_reversal_enable;
  logic output_level_set;
  logic output_level_clear;
  logic oneshot_en;
  logic [1:0] edge_first;
  logic [1:0] edge_second;
  logic [1:0] clk_sel;
  logic cap_first_en;
  logic reverse_phase_capture_select;
  logic cap_second_en;
  logic [15:0] capcomp_first;
  logic [15:0] capcomp_second;
  logic [15:0] timer_count;
  logic [1:0] div_cnt;
  logic [1:0] in_prev;
  logic started_once;
  logic [1:0] edge_pend;
  logic rev_pend;
  logic [1:0] irq_pend;
  logic ovf_hold;
  logic oneshot_active;
  logic out_level;
  logic wr_pend;
  logic [7:0] wr_addr;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // Zero wait states: a write lands at the edge that ends its data phase
  wire bus_take = i_hready && i_ahb.hsel && i_ahb.htrans == timer_cc_pkg::htrans_nonseq;
  wire rd_take = bus_take && !i_ahb.hwrite;
  wire wr_take = bus_take && i_ahb.hwrite;
  wire [31:0] wdata = i_ahb.hwdata;
  wire wr_mode = wr_pend && wr_addr == timer_cc_pkg::mode_control_off;
  wire wr_outctl = wr_pend && wr_addr == timer_cc_pkg::output_control_off;
  wire wr_presc = wr_pend && wr_addr == timer_cc_pkg::prescaler_mode_off;
  wire wr_capctl = wr_pend && wr_addr == timer_cc_pkg::capture_control_off;
  wire wr_cc1 = wr_pend && wr_addr == timer_cc_pkg::capcomp_first_off;
  wire wr_cc2 = wr_pend && wr_addr == timer_cc_pkg::capcomp_second_off;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_ahb.haddr)
      timer_cc_pkg::mode_control_off: begin
        rd_mux[timer_cc_pkg::mode_pos +: 2] = mode;
        rd_mux[timer_cc_pkg::overflow_pos] = overflow_flag;
      end
      timer_cc_pkg::output_control_off: begin
        rd_mux[timer_cc_pkg::first_rev_pos] = first_rev_en;
        rd_mux[timer_cc_pkg::second_rev_pos] = second_match_reversal_enable;
        rd_mux[timer_cc_pkg::level_set_pos] = output_level_set;
        rd_mux[timer_cc_pkg::level_clear_pos] = output_level_clear;
        rd_mux[timer_cc_pkg::oneshot_en_pos] = oneshot_en;
      end
      timer_cc_pkg::prescaler_mode_off: begin
        rd_mux[timer_cc_pkg::edge_first_pos +: 2] = edge_first;
        rd_mux[timer_cc_pkg::edge_second_pos +: 2] = edge_second;
        rd_mux[timer_cc_pkg::clk_sel_pos +: 2] = clk_sel;
      end
      timer_cc_pkg::capture_control_off: begin
        rd_mux[timer_cc_pkg::cap_first_pos] = cap_first_en;
        rd_mux[timer_cc_pkg::reverse_phase_pos] = reverse_phase_capture_select;
        rd_mux[timer_cc_pkg::cap_second_pos] = cap_second_en;
      end
      // A capture landing in this cycle is not in the read value
      timer_cc_pkg::capcomp_first_off: rd_mux[15:0] = capcomp_first;
      timer_cc_pkg::capcomp_second_off: rd_mux[15:0] = capcomp_second;
      timer_cc_pkg::timer_count_off: rd_mux[15:0] = timer_count;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_ahb <= '0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      o_ahb.hreadyout <= 1'b1;
      // Always OKAY: unmapped addresses read zero and ignore writes
      o_ahb.hresp <= 1'b0;
      wr_pend <= wr_take;
      if (bus_take) begin
        wr_addr <= i_ahb.haddr;
      end
      if (rd_take) begin
        o_ahb.hrdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Edge detection and count clock
  wire running = mode != timer_cc_pkg::mode_stop;
  wire [1:0] in_now = {i_second_capture_input, i_first_capture_input};
  wire [1:0] rise = in_now & ~in_prev;
  wire [1:0] fall = ~in_now & in_prev;
  wire [1:0] valid_edge;
  wire first_rev_edge;
  assign valid_edge[0] = (edge_first[0] && rise[0]) || (!edge_first[0] && !edge_first[1] && fall[0])
    || (edge_first == timer_cc_pkg::edge_both && fall[0]);
  assign valid_edge[1] = (edge_second[0] && rise[1])
    || (!edge_second[0] && !edge_second[1] && fall[1])
    || (edge_second == timer_cc_pkg::edge_both && fall[1]);
  assign first_rev_edge = (edge_first == timer_cc_pkg::edge_rise && fall[0])
    || (edge_first == timer_cc_pkg::edge_fall && rise[0])
    || (edge_first == timer_cc_pkg::edge_both && (rise[0] || fall[0]));

  wire clk_ext = clk_sel == timer_cc_pkg::clk_from_input;
  // Free-running prescaler: start is not aligned to it
  wire div_tick = (div_cnt & ((2'h1 << clk_sel) - 2'h1)) == 2'h0;
  wire tick = running && (clk_ext ? valid_edge[0] : div_tick);

  // Edges seen between count clocks are held until the next one
  wire [1:0] edge_now = edge_pend | (valid_edge & {1'b1, !clk_ext});
  wire rev_now = rev_pend || (first_rev_edge && !clk_ext);

  ////////////////////////////////////////////////////////////////////////////////
  // Counter, compare and capture events
  // A register in capture mode gives no match, so a capture cannot toggle the pin
  wire match1 = tick && timer_count == capcomp_first && !cap_first_en;
  wire match2 = tick && timer_count == capcomp_second && !cap_second_en;
  wire clear_on_match = mode == timer_cc_pkg::mode_clear_match && match1;
  wire clear_on_edge = tick && mode == timer_cc_pkg::mode_clear_edge && edge_now[0];
  wire oneshot_ok = oneshot_en && mode != timer_cc_pkg::mode_clear_match;
  wire sw_trig = wr_outctl && wdata[timer_cc_pkg::oneshot_trig_pos] && running;
  // A retrigger while armed restarts the count; software waits for the pulse end
  wire oneshot_trig = oneshot_ok && (sw_trig || clear_on_edge);
  wire wrap = tick && timer_count == timer_cc_pkg::count_max;
  wire ovf_event = wrap || (clear_on_match && capcomp_first == timer_cc_pkg::count_max);
  wire [15:0] next_count = (clear_on_match || clear_on_edge || sw_trig && oneshot_ok) ? 16'h0000
    : (tick ? timer_count + 16'h0001 : timer_count);

  wire cap1_trig = tick && cap_first_en
    && (reverse_phase_capture_select ? rev_now : edge_now[1]);
  wire cap2_trig = tick && cap_second_en && edge_now[0];
  // Reverse-phase capture is silent; second input edge then only interrupts
  wire ext_irq1 = tick && cap_first_en && reverse_phase_capture_select && edge_now[1];

  // One-shot gates compare toggles to the armed pulse window
  wire toggle_ok = !oneshot_ok || oneshot_active;
  wire toggle = toggle_ok && ((match1 && first_rev_en)
    || (match2 && second_match_reversal_enable));

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      div_cnt <= timer_cc_pkg::clk_div_reset;
      in_prev <= 2'h0;
      started_once <= 1'b0;
      edge_pend <= 2'h0;
      rev_pend <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
      // Reset leaves in_prev low, so a high input at first start is a rising edge
      if (running || started_once) begin
        in_prev <= in_now;
      end
      if (running) begin
        started_once <= 1'b1;
      end
      edge_pend <= tick || !running ? 2'h0 : edge_now;
      rev_pend <= !tick && running && rev_now;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      timer_count <= 16'h0000;
      overflow_flag <= 1'b0;
      ovf_hold <= 1'b0;
      irq_pend <= 2'h0;
      o_first_match_irq <= 1'b0;
      o_second_match_irq <= 1'b0;
      oneshot_active <= 1'b0;
    end else begin
      // Stopping clears the count, so every start counts from zero
      timer_count <= running ? next_count : 16'h0000;
      // Set wins over clear; clear is ignored until the count clock after wrap
      if (ovf_event) begin
        overflow_flag <= 1'b1;
      end else if (wr_mode && !wdata[timer_cc_pkg::overflow_pos] && !ovf_hold) begin
        overflow_flag <= 1'b0;
      end
      if (ovf_event) begin
        ovf_hold <= 1'b1;
      end else if (tick || !running) begin
        ovf_hold <= 1'b0;
      end
      // Capture interrupts come out at the following count clock
      if (tick) begin
        irq_pend <= {cap2_trig, cap1_trig && !reverse_phase_capture_select};
      end else if (!running) begin
        irq_pend <= 2'h0;
      end
      o_first_match_irq <= match1 || ext_irq1 || (tick && irq_pend[0]);
      o_second_match_irq <= match2 || (tick && irq_pend[1]);
      if (!oneshot_ok || !running || (match2 && oneshot_active)) begin
        oneshot_active <= 1'b0;
      end else if (oneshot_trig) begin
        oneshot_active <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Capture/compare registers
  // Values are kept over a stop, but software must not rely on that
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      capcomp_first <= timer_cc_pkg::capcomp_reset;
      capcomp_second <= timer_cc_pkg::capcomp_reset;
    end else begin
      // Capture takes priority over a software write in the same cycle
      if (cap1_trig && !(reverse_phase_capture_select && edge_now[1] && !rev_now)) begin
        capcomp_first <= timer_count;
      end else if (wr_cc1) begin
        capcomp_first <= wdata[15:0];
      end
      if (cap2_trig) begin
        capcomp_second <= timer_count;
      end else if (wr_cc2) begin
        capcomp_second <= wdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mode <= timer_cc_pkg::mode_stop;
      first_rev_en <= 1'b0;
      second_match_reversal_enable <= 1'b0;
      output_level_set <= 1'b0;
      output_level_clear <= 1'b0;
      oneshot_en <= 1'b0;
      edge_first <= timer_cc_pkg::edge_fall;
      edge_second <= timer_cc_pkg::edge_fall;
      clk_sel <= timer_cc_pkg::clk_div_reset;
      cap_first_en <= 1'b0;
      reverse_phase_capture_select <= 1'b0;
      cap_second_en <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode <= wdata[timer_cc_pkg::mode_pos +: 2];
      end
      if (wr_outctl) begin
        first_rev_en <= wdata[timer_cc_pkg::first_rev_pos];
        second_match_reversal_enable <= wdata[timer_cc_pkg::second_rev_pos];
        output_level_set <= wdata[timer_cc_pkg::level_set_pos];
        output_level_clear <= wdata[timer_cc_pkg::level_clear_pos];
        oneshot_en <= wdata[timer_cc_pkg::oneshot_en_pos];
      end
      if (wr_presc) begin
        edge_first <= wdata[timer_cc_pkg::edge_first_pos +: 2];
        edge_second <= wdata[timer_cc_pkg::edge_second_pos +: 2];
        clk_sel <= wdata[timer_cc_pkg::clk_sel_pos +: 2];
      end
      if (wr_capctl) begin
        cap_first_en <= wdata[timer_cc_pkg::cap_first_pos];
        reverse_phase_capture_select <= wdata[timer_cc_pkg::reverse_phase_pos];
        cap_second_en <= wdata[timer_cc_pkg::cap_second_pos];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timer output level
  // Level bits written while running are ignored, so a stray write cannot glitch the pin
  wire lvl_set = wr_outctl && wdata[timer_cc_pkg::level_set_pos]
    && !wdata[timer_cc_pkg::level_clear_pos];
  wire lvl_clr = wr_outctl && !wdata[timer_cc_pkg::level_set_pos]
    && wdata[timer_cc_pkg::level_clear_pos];

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      out_level <= 1'b0;
      o_timer_output_pin <= 1'b0;
    end else begin
      // Forcing acts only while stopped; 00 and 11 leave the level
      if (!running && lvl_set) begin
        out_level <= 1'b1;
      end else if (!running && lvl_clr) begin
        out_level <= 1'b0;
      end else if (running && toggle) begin
        out_level <= !out_level; // starts from the forced level
      end
      o_timer_output_pin <= out_level;
    end
  end

endmodule

// *** timer_cc_sva.sv ***
// Checker for the capture/compare timer, bound to its top ports.
// Assumes hready is fed back from o_ahb.hreadyout.
`timescale 1ns/1ps
module timer_cc_sva (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Bus
  input wire timer_cc_pkg::ahb_req_t i_ahb,
  input wire logic i_hready,
  input wire timer_cc_pkg::ahb_rsp_t o_ahb,
  // Pins
  input wire logic i_first_capture_input,
  input wire logic i_second_capture_input,
  input wire logic o_timer_output_pin,
  input wire logic o_first_match_irq,
  input wire logic o_second_match_irq
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] mode;
  logic [7:0] waddr;
  logic [2:0] wsh;
  logic wpend;
  logic set_hi;
  logic set_lo;
  logic set_none;
  wire taken = i_hready && i_ahb.hsel && i_ahb.htrans == timer_cc_pkg::htrans_nonseq;
  wire stopped = mode == timer_cc_pkg::mode_stop;
  wire lvl_wr = wpend && waddr == timer_cc_pkg::output_control_off && stopped;
  wire lv_s = i_ahb.hwdata[timer_cc_pkg::level_set_pos];
  wire lv_c = i_ahb.hwdata[timer_cc_pkg::level_clear_pos];
  wire cnt_rd = taken && !i_ahb.hwrite && i_ahb.haddr == timer_cc_pkg::timer_count_off;
  // Mode shadow: a write lands when its data phase ends
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wpend <= 1'b0;
      mode <= timer_cc_pkg::mode_stop;
    end else begin
      wpend <= taken && i_ahb.hwrite;
      if (wpend && waddr == timer_cc_pkg::mode_control_off) begin
        mode <= i_ahb.hwdata[1:0];
      end
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (taken) begin
      waddr <= i_ahb.haddr;
    end
    wsh <= {wsh[1:0], wpend};
    set_hi <= lvl_wr && lv_s && !lv_c;
    set_lo <= lvl_wr && !lv_s && lv_c;
    set_none <= lvl_wr && !lv_s && !lv_c;
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_first_pulse:
    assert property (o_first_match_irq |=> !o_first_match_irq)
    else $error("first event pulse too long");
  chk_second_pulse:
    assert property (o_second_match_irq |=> !o_second_match_irq)
    else $error("second event pulse too long");
  // Only an event or a recent register write may move the pin
  chk_pin_cause:
    assert property ($changed(o_timer_output_pin) |->
      $past(o_first_match_irq) || $past(o_second_match_irq) || (|wsh))
    else $error("pin moved without cause");
  chk_start_level:
    assert property (stopped ##1 !stopped |-> $stable(o_timer_output_pin) [*2])
    else $error("pin jumped at start");
  chk_stop_quiet:
    assert property (stopped [*4] |-> !o_first_match_irq && !o_second_match_irq)
    else $error("event while stopped");
  chk_stop_count:
    assert property (stopped [*3] ##0 cnt_rd |=> o_ahb.hrdata == 32'h0)
    else $error("count not zero while stopped");
  chk_force_high:
    assert property (set_hi |-> ##[0:2] o_timer_output_pin)
    else $error("forced high not seen");
  chk_force_low:
    assert property (set_lo |-> ##[0:2] !o_timer_output_pin)
    else $error("forced low not seen");
  chk_force_hold:
    assert property (set_none |-> ##2 $stable(o_timer_output_pin) [*3])
    else $error("forced level lost");
  cover property (o_first_match_irq);
  cover property (o_second_match_irq);
  cover property ($rose(o_timer_output_pin));
endmodule

// *** timer_pin_partner.sv ***
// Pulse sources on the two capture inputs.
// Assumes the bench raises a fire bit for one cycle per pulse.
`timescale 1ns/1ps
module timer_pin_partner (
  // Clock
  input wire logic i_sys_clk,
  // Commands
  input wire logic [1:0] i_fire,
  input wire logic [1:0] i_level,
  // Pins
  output logic o_first_capture_input,
  output logic o_second_capture_input
);
  // Twelve cycles outlast two count clocks even at the slowest divider
  logic [3:0] left0 = 4'h0;
  logic [3:0] left1 = 4'h0;
  always @(posedge i_sys_clk) begin
    left0 <= i_fire[0] ? 4'hc : left0 - {3'h0, left0 != 4'h0};
    left1 <= i_fire[1] ? 4'hc : left1 - {3'h0, left1 != 4'h0};
  end
  assign o_first_capture_input = i_level[0] || left0 != 4'h0;
  assign o_second_capture_input = i_level[1] || left1 != 4'h0;
endmodule

// *** tb.sv ***
// Self-checking bench for the capture/compare timer.
// Assumes the design package, the checker and the pin model.
`timescale 1ns/1ps
module tb;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  timer_cc_pkg::ahb_req_t req = '0;
  timer_cc_pkg::ahb_rsp_t rsp;
  logic [1:0] fire = 2'h0;
  logic [1:0] level = 2'h2;
  logic cap1;
  logic cap2;
  logic pin;
  logic irq1;
  logic irq2;
  logic [31:0] rd;
  logic [31:0] seed = 32'ha81d;
  logic [15:0] cc1;
  logic [15:0] cap_a;
  int miscompares = 0;
  int tests_run = 0;
  int n1 = 0;
  int n2 = 0;
  int cyc;
  `define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("FAIL t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
  always #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    n1 <= n1 + int'(irq1 === 1'b1);
    n2 <= n2 + int'(irq2 === 1'b1);
  end
  timer_capture_compare_output_control dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ahb(req), .i_hready(rsp.hreadyout),
    .o_ahb(rsp), .i_first_capture_input(cap1), .i_second_capture_input(cap2),
    .o_timer_output_pin(pin), .o_first_match_irq(irq1), .o_second_match_irq(irq2)
  );
  timer_pin_partner pins (
    .i_sys_clk(i_sys_clk), .i_fire(fire), .i_level(level),
    .o_first_capture_input(cap1), .o_second_capture_input(cap2)
  );
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Clear-on-match runs compare+1 ticks, one tick per 2**sel cycles
  function automatic int period(input logic [15:0] c, input int sel);
    return (int'(c) + 1) << sel;
  endfunction
  task automatic edge_rdy();
    int t;
    t = 0;
    @(posedge i_sys_clk);
    while (rsp.hreadyout !== 1'b1 && t < 64) begin
      @(posedge i_sys_clk);
      t++;
    end
    if (t >= 64) begin
      miscompares++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    req.hsel <= 1'b1;
    req.haddr <= a;
    req.htrans <= timer_cc_pkg::htrans_nonseq;
    req.hwrite <= w;
    req.hsize <= 3'h2;
    edge_rdy();
    req.hsel <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= d;
    edge_rdy();
    rd = rsp.hrdata;
  endtask
  task automatic wait_irq1(input int lim);
    cyc = 0;
    do begin
      @(posedge i_sys_clk);
      cyc++;
    end while (irq1 !== 1'b1 && cyc < lim);
    if (irq1 !== 1'b1) begin
      miscompares++;
    end
  endtask
  task automatic pulse(input logic [1:0] f);
    fire <= f;
    @(posedge i_sys_clk);
    fire <= 2'h0;
    repeat (30) @(posedge i_sys_clk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge i_sys_clk);
    miscompares++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int b1;
    int b2;
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    // Second input already high: first start sees a rising edge
    bus(1, timer_cc_pkg::prescaler_mode_off, 32'h4);
    bus(1, timer_cc_pkg::capture_control_off, 32'h1);
    bus(0, timer_cc_pkg::timer_count_off, 32'h0);
    `CHK(rd, 32'h0);
    for (int k = 0; k < 2; k++) begin
      b1 = n1;
      bus(1, timer_cc_pkg::mode_control_off, 32'h1);
      repeat (20) @(posedge i_sys_clk);
      `CHK(n1 - b1, 1 - k);
      bus(1, timer_cc_pkg::mode_control_off, 32'h0);
      level <= 2'h0;
      repeat (4) @(posedge i_sys_clk);
      level <= {k == 0, 1'b0};
      repeat (4) @(posedge i_sys_clk);
    end
    $display("test start_edge done");
    // Levels are forced only while stopped
    bus(1, timer_cc_pkg::output_control_off, 32'h4);
    repeat (3) @(posedge i_sys_clk);
    `CHK(pin, 1'b1);
    bus(1, timer_cc_pkg::output_control_off, 32'h0);
    repeat (3) @(posedge i_sys_clk);
    `CHK(pin, 1'b1);
    bus(1, timer_cc_pkg::output_control_off, 32'h8);
    repeat (3) @(posedge i_sys_clk);
    `CHK(pin, 1'b0);
    bus(1, timer_cc_pkg::output_control_off, 32'h4);
    bus(1, timer_cc_pkg::output_control_off, 32'h1);
    bus(1, timer_cc_pkg::capture_control_off, 32'h0);
    $display("test force_level done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      cc1 = 16'h4 + {11'h0, seed[4:0]};
      bus(1, timer_cc_pkg::mode_control_off, 32'h0);
      bus(1, timer_cc_pkg::capcomp_first_off, {16'h0, cc1});
      bus(1, timer_cc_pkg::capcomp_second_off, {17'h0, cc1[15:1]});
      bus(1, timer_cc_pkg::prescaler_mode_off, 32'(i % 3) << 4);
      bus(1, timer_cc_pkg::mode_control_off, 32'h3);
      if (i == 0) begin
        `CHK(pin, 1'b1);
      end
      wait_irq1(3000);
      b1 = n2;
      wait_irq1(3000);
      `CHK(cyc, period(cc1, i % 3));
      `CHK(n2 - b1, 1);
    end
    $display("test match_period done");
    bus(1, timer_cc_pkg::mode_control_off, 32'h0);
    bus(1, timer_cc_pkg::capcomp_first_off, 32'hffff);
    bus(1, timer_cc_pkg::prescaler_mode_off, 32'h0);
    bus(1, timer_cc_pkg::mode_control_off, 32'h3);
    wait_irq1(70000);
    repeat (4) @(posedge i_sys_clk);
    bus(0, timer_cc_pkg::mode_control_off, 32'h0);
    `CHK(rd[2:0], 3'h7);
    bus(1, timer_cc_pkg::mode_control_off, 32'h3);
    bus(0, timer_cc_pkg::mode_control_off, 32'h0);
    `CHK(rd[2:0], 3'h3);
    $display("test overflow done");
    // Reverse phase: first input fall goes to the first register silently
    bus(1, timer_cc_pkg::mode_control_off, 32'h0);
    bus(1, timer_cc_pkg::prescaler_mode_off, 32'h5);
    bus(1, timer_cc_pkg::capture_control_off, 32'h7);
    bus(1, timer_cc_pkg::mode_control_off, 32'h1);
    b1 = n1;
    b2 = n2;
    pulse(2'h1);
    `CHK(n1 - b1, 0);
    `CHK(n2 - b2, 1);
    bus(0, timer_cc_pkg::capcomp_first_off, 32'h0);
    cap_a = rd[15:0];
    b1 = n1;
    pulse(2'h2);
    `CHK(n1 - b1, 1);
    bus(0, timer_cc_pkg::capcomp_first_off, 32'h0);
    `CHK(rd[15:0], cap_a);
    bus(0, timer_cc_pkg::capcomp_second_off, 32'h0);
    cc1 = rd[15:0];
    bus(0, timer_cc_pkg::timer_count_off, 32'h0);
    `CHK(16'(rd[15:0] - cc1) < 16'h100, 1'b1);
    $display("test capture done");
    // One-shot: compare toggles only inside an armed pulse
    bus(1, timer_cc_pkg::mode_control_off, 32'h0);
    bus(1, timer_cc_pkg::capture_control_off, 32'h0);
    bus(1, timer_cc_pkg::prescaler_mode_off, 32'h1);
    bus(1, timer_cc_pkg::capcomp_first_off, 32'h10);
    bus(1, timer_cc_pkg::capcomp_second_off, 32'h20);
    bus(1, timer_cc_pkg::output_control_off, 32'h8);
    bus(1, timer_cc_pkg::output_control_off, 32'h13);
    bus(1, timer_cc_pkg::mode_control_off, 32'h1);
    repeat (24) @(posedge i_sys_clk);
    `CHK(pin, 1'b0);
    bus(1, timer_cc_pkg::output_control_off, 32'h33);
    repeat (24) @(posedge i_sys_clk);
    `CHK(pin, 1'b1);
    repeat (16) @(posedge i_sys_clk);
    `CHK(pin, 1'b0);
    $display("test oneshot done");
    // Clear on first input rise: count restarts at the edge
    bus(1, timer_cc_pkg::mode_control_off, 32'h0);
    bus(1, timer_cc_pkg::mode_control_off, 32'h2);
    pulse(2'h1);
    bus(0, timer_cc_pkg::timer_count_off, 32'h0);
    `CHK(rd[15:0], 16'h1d);
    $display("test edge_clear done");
    give_verdict();
  end
endmodule
bind timer_capture_compare_output_control timer_cc_sva chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ahb(i_ahb), .i_hready(i_hready),
  .o_ahb(o_ahb), .i_first_capture_input(i_first_capture_input),
  .i_second_capture_input(i_second_capture_input), .o_timer_output_pin(o_timer_output_pin),
  .o_first_match_irq(o_first_match_irq), .o_second_match_irq(o_second_match_irq)
);
